// ### src/qbpu_consts.vh
/*
 * Constants for the quasi-bidirectional port unit: reset values, bit
 * positions of alternate functions and machine-cycle phase numbers.
 * Assumes one clock period stands for one oscillator period.
 */
// Contract
// R1 - Four bidirectional ports, each bit a latch, driver and input buffer.
// R2 - Each latch bit loads internal bus on the write-to-latch strobe.
// R3 - Read-latch puts latch on bus; read-pin puts pin level on bus.
// R4 - Port zero carries multiplexed low address and data during bus use.
// R5 - Port two drives high address only for 16-bit accesses, else latch.
// R6 - During bus use port-two latch holds; port-zero latch loads all ones.
// R7 - Ports zero and two are not general I/O while serving the bus.
// R8 - Port three bits carry serial, interrupt, timer and strobe functions.
// R9 - Larger variant: port one bits 0 and 1 serve third timer.
// R10 - Alternate output reaches pin only while latch holds one.
// R11 - Latch one lets pin follow alternate output; pin feeds alternate input.
// R12 - Input use needs latch one; external source may pull low.
// R13 - Port-zero pull-up only while driving ones during bus use.
// R14 - Port-zero latch one outside bus use floats the pin.
// R15 - Reset sets all latches to one; writing one restores input.
// R16 - Machine cycle is six states of two phases, twelve periods.
// R17 - Address strobe high STATE1_PHASE2 to S2P1 and S4P2 to S5P1.
// R18 - Two fetches per cycle, skipped during external data move.
// R19 - Latch updates at STATE6_PHASE2; pin shows it at next S1P1; the unit's pin outputs show it at S2P1.
// R20 - Read-modify-write uses latch value; bit ops rewrite whole byte.
// R21 - Pin driven low when effective output zero, weakly high otherwise.
`ifndef QBPU_CONSTS_VH
`define QBPU_CONSTS_VH
`define QBPU_LATCH_RST   8'hff
`define QBPU_PHASES      4'hc
`define QBPU_PH_S1P1     4'h0
`define QBPU_PH_STATE1_PHASE2     4'h1
`define QBPU_PH_S2P1     4'h2
`define QBPU_PH_S4P1     4'h6
`define QBPU_PH_S4P2     4'h7
`define QBPU_PH_S5P1     4'h8
`define QBPU_PH_STATE6_PHASE2     4'hb
`define QBPU_P3_RXD      0
`define QBPU_P3_TXD      1
`define QBPU_P3_IRQA     2
`define QBPU_P3_IRQB     3
`define QBPU_P3_T0       4
`define QBPU_P3_T1       5
`define QBPU_P3_WR       6
`define QBPU_P3_RD       7
`define QBPU_P1_T2       0
`define QBPU_P1_THIRD_TIMER_TRIGGER     1
`endif

// ### src/qbpu_port_unit.v
/*
 * Four 8-bit port latches with drivers, pin synchronisers, the external
 * bus multiplexing of ports zero and two and the machine-cycle framing.
 * Assumes the CPU core issues strobes on the same clock; pins are async.
 */
`timescale 1ns/1ns
`include "qbpu_consts.vh"
module qbpu_port_unit #(
  parameter LARGE_VARIANT = 1
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       sys_rst_i,
  // CPU side strobes
  input  wire [1:0] port_sel_i,
  input  wire       write_latch_i,
  input  wire       read_latch_i,
  input  wire       read_pin_i,
  input  wire       bit_op_i,
  input  wire [2:0] bit_sel_i,
  input  wire [7:0] bus_wdata_i,
  output reg  [7:0] bus_rdata_o,
  // External memory bus control
  input  wire       ext_bus_i,
  input  wire       addr16_i,
  input  wire       ext_data_phase_i,
  input  wire       ext_write_i,
  input  wire       ext_data_move_i,
  input  wire [7:0] ext_addr_lo_i,
  input  wire [7:0] ext_addr_hi_i,
  input  wire [7:0] ext_wdata_i,
  output reg  [7:0] ext_rdata_o,
  // Alternate outputs from peripherals
  input  wire       alt_txd_i,
  input  wire       alt_wr_i,
  input  wire       alt_rd_i,
  // Alternate inputs to peripherals
  output reg        alt_rxd_o,
  output reg        ext_irq_a_o,
  output reg        ext_irq_b_o,
  output reg        timer_zero_count_in_o,
  output reg        timer_one_count_in_o,
  output reg        third_timer_count_in_o,
  output reg        third_timer_trigger_o,
  // Machine cycle framing
  output reg        addr_latch_strobe_o,
  output reg        code_fetch_o,
  output reg  [3:0] phase_o,
  // Pins: input, output, enable (enable high while driven)
  input  wire [7:0] p0_pin_i,
  output reg  [7:0] p0_pin_o,
  output reg  [7:0] p0_pin_oe_o,
  input  wire [7:0] p1_pin_i,
  output reg  [7:0] p1_pin_o,
  output reg  [7:0] p1_pin_oe_o,
  input  wire [7:0] p2_pin_i,
  output reg  [7:0] p2_pin_o,
  output reg  [7:0] p2_pin_oe_o,
  input  wire [7:0] p3_pin_i,
  output reg  [7:0] p3_pin_o,
  output reg  [7:0] p3_pin_oe_o
);

  // ********************************
  // Machine cycle phase counter
  // ********************************
  reg  [3:0] phase;
  wire [3:0] next_phase = (phase == `QBPU_PHASES - 4'h1) ? 4'h0 : phase + 4'h1;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      phase <= 4'h0;
    end else begin
      phase <= next_phase; // R16
    end
  end

  // ********************************
  // Pin synchronisers
  // ********************************
  reg [31:0] pin_meta;
  reg [31:0] pin_sync;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_meta <= 32'hffffffff;
      pin_sync <= 32'hffffffff;
    end else begin
      pin_meta <= {p3_pin_i, p2_pin_i, p1_pin_i, p0_pin_i};
      pin_sync <= pin_meta;
    end
  end

  // ********************************
  // Port latches
  // ********************************
  reg  [7:0] port_zero_latch;
  reg  [7:0] port_one_latch;
  reg  [7:0] port_two_latch;
  reg  [7:0] port_three_latch;
  reg  [7:0] pend_data;
  reg  [1:0] pend_port;
  reg        pend_valid;

  function [7:0] sel_byte;
    input [1:0] sel;
    input [31:0] word;
    begin
      case (sel)
        2'd0:    sel_byte = word[7:0];
        2'd1:    sel_byte = word[15:8];
        2'd2:    sel_byte = word[23:16];
        default: sel_byte = word[31:24];
      endcase
    end
  endfunction

  wire [31:0] latch_word = {port_three_latch, port_two_latch,
                            port_one_latch, port_zero_latch};
  wire [7:0]  sel_latch  = sel_byte(port_sel_i, latch_word);
  // Bit op: read all eight latch bits, modify one, rewrite byte
  wire [7:0]  bit_mask   = 8'h01 << bit_sel_i;
  wire [7:0]  wr_value   = bit_op_i ?
                           ((sel_latch & ~bit_mask) | (bus_wdata_i & bit_mask)) :
                           bus_wdata_i; // R20

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pend_valid <= 1'b0;
      pend_port  <= 2'd0;
      pend_data  <= 8'h00;
    end else if (write_latch_i) begin
      pend_valid <= 1'b1;
      pend_port  <= port_sel_i;
      pend_data  <= wr_value; // R2
    end else if (phase == `QBPU_PH_STATE6_PHASE2) begin
      pend_valid <= 1'b0;
    end
  end

  // Latch takes the held write at STATE6_PHASE2
  wire commit = pend_valid && (phase == `QBPU_PH_STATE6_PHASE2); // R19

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      port_zero_latch  <= `QBPU_LATCH_RST; // R15
      port_one_latch   <= `QBPU_LATCH_RST;
      port_two_latch   <= `QBPU_LATCH_RST;
      port_three_latch <= `QBPU_LATCH_RST;
    end else begin
      if (ext_bus_i)
        port_zero_latch <= `QBPU_LATCH_RST; // R6
      else if (commit && pend_port == 2'd0)
        port_zero_latch <= pend_data;
      if (commit && pend_port == 2'd1)
        port_one_latch <= pend_data;
      if (commit && pend_port == 2'd2 && !ext_bus_i)
        port_two_latch <= pend_data; // R6
      if (commit && pend_port == 2'd3)
        port_three_latch <= pend_data;
    end
  end

  // ********************************
  // Output sampling at phase 1
  // ********************************
  // Drivers sample latches on each phase one and at commit; commit sees the old latch, so a write reaches them at S1P2
  reg [31:0] drv_latch;
  wire       phase_one = ~phase[0];

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      drv_latch <= 32'hffffffff;
    end else if (phase_one || commit) begin
      drv_latch <= (commit ? {32{1'b0}} : latch_word) |
                   (commit ? latch_word : {32{1'b0}}); // R19
    end
  end

  // ********************************
  // Pin drivers
  // ********************************
  wire [7:0] alt3_out = {alt_rd_i, alt_wr_i, 1'b1, 1'b1, 1'b1, 1'b1,
                         alt_txd_i, 1'b1}; // R8
  wire [7:0] p0_bus_val = ext_data_phase_i ? ext_wdata_i : ext_addr_lo_i;
  wire       p0_bus_drv = ext_bus_i && (!ext_data_phase_i || ext_write_i);
  reg  [7:0] next_p0_o;
  reg  [7:0] next_p0_oe;
  reg  [7:0] next_p2_eff;
  reg  [7:0] next_p3_eff;

  always @* begin
    if (ext_bus_i) begin
      next_p0_o  = p0_bus_val; // R4
      next_p0_oe = p0_bus_drv ? 8'hff : 8'h00; // R13 R7
    end else begin
      next_p0_o  = 8'h00;
      next_p0_oe = ~drv_latch[7:0]; // R14
    end
    next_p2_eff = (ext_bus_i && addr16_i) ? ext_addr_hi_i : drv_latch[23:16]; // R5 R7
    next_p3_eff = drv_latch[31:24] & alt3_out; // R10 R11
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      p0_pin_o    <= 8'h00;
      p0_pin_oe_o <= 8'h00;
      p1_pin_o    <= 8'hff;
      p1_pin_oe_o <= 8'h00;
      p2_pin_o    <= 8'hff;
      p2_pin_oe_o <= 8'h00;
      p3_pin_o    <= 8'hff;
      p3_pin_oe_o <= 8'h00;
    end else begin
      p0_pin_o    <= next_p0_o;
      p0_pin_oe_o <= next_p0_oe;
      // Strong low only; high is the weak pull-up
      p1_pin_o    <= drv_latch[15:8]; // R21 R12
      p1_pin_oe_o <= ~drv_latch[15:8];
      p2_pin_o    <= next_p2_eff;
      p2_pin_oe_o <= ~next_p2_eff; // R21
      p3_pin_o    <= next_p3_eff;
      p3_pin_oe_o <= ~next_p3_eff; // R21 R12
    end
  end

  // ********************************
  // CPU reads, bus read data, alternate inputs
  // ********************************
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_rdata_o            <= 8'h00;
      ext_rdata_o            <= 8'h00;
      alt_rxd_o              <= 1'b1;
      ext_irq_a_o            <= 1'b1;
      ext_irq_b_o            <= 1'b1;
      timer_zero_count_in_o  <= 1'b1;
      timer_one_count_in_o   <= 1'b1;
      third_timer_count_in_o <= 1'b1;
      third_timer_trigger_o  <= 1'b1;
    end else begin
      if (read_latch_i)
        bus_rdata_o <= sel_latch; // R3
      else if (read_pin_i)
        bus_rdata_o <= sel_byte(port_sel_i, pin_sync); // R3 R1
      if (ext_bus_i && ext_data_phase_i && !ext_write_i)
        ext_rdata_o <= pin_sync[7:0]; // R4
      alt_rxd_o              <= pin_sync[24 + `QBPU_P3_RXD]; // R11
      ext_irq_a_o            <= pin_sync[24 + `QBPU_P3_IRQA];
      ext_irq_b_o            <= pin_sync[24 + `QBPU_P3_IRQB];
      timer_zero_count_in_o  <= pin_sync[24 + `QBPU_P3_T0];
      timer_one_count_in_o   <= pin_sync[24 + `QBPU_P3_T1];
      third_timer_count_in_o <= LARGE_VARIANT ? pin_sync[8 + `QBPU_P1_T2] : 1'b1; // R9
      third_timer_trigger_o  <= LARGE_VARIANT ? pin_sync[8 + `QBPU_P1_THIRD_TIMER_TRIGGER] : 1'b1;
    end
  end

  // ********************************
  // Strobe and fetch framing
  // ********************************
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_latch_strobe_o <= 1'b0;
      code_fetch_o        <= 1'b0;
      phase_o             <= 4'h0;
    end else begin
      phase_o             <= next_phase;
      addr_latch_strobe_o <= (next_phase == `QBPU_PH_STATE1_PHASE2) ||
                             (next_phase == `QBPU_PH_S2P1) ||
                             (next_phase == `QBPU_PH_S4P2) ||
                             (next_phase == `QBPU_PH_S5P1); // R17
      code_fetch_o        <= !ext_data_move_i &&
                             ((next_phase == `QBPU_PH_STATE1_PHASE2) ||
                              (next_phase == `QBPU_PH_S4P1)); // R18
    end
  end

endmodule // qbpu_port_unit

// ### bench/qbpu_pin_model.sv
/* Far-side pin model: unit drive, external source, pull-ups.
   Assumes pins packed as ports 3..0 in 32 bits. */
`timescale 1ns/1ns
module qbpu_pin_model (
  // Clock
  input  wire         clk_i,
  // Unit drive and external source
  input  wire  [31:0] drv_i,
  input  wire  [31:0] oe_i,
  input  wire  [31:0] ext_v_i,
  input  wire  [31:0] ext_en_i,
  // Resolved pins
  output logic [31:0] pin_o
);
  logic [7:0] flt = 8'h5a;
  // Floating port zero keeps no value
  always @(posedge clk_i) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (oe_i[i]) pin_o[i] = drv_i[i];
      else if (ext_en_i[i]) pin_o[i] = ext_v_i[i];
      else pin_o[i] = (i < 8) ? flt[i % 8] : 1'b1;
    end
  end
endmodule // qbpu_pin_model

// ### bench/qbpu_port_unit_chk.sv
/* Port unit checker: framing, drivers, read paths.
   Assumes it is bound into every unit instance. */
`timescale 1ns/1ns
module qbpu_port_unit_chk (
  // Clock and reset
  input wire       clk_i,
  input wire       sys_rst_i,
  // Strobes
  input wire [1:0] port_sel_i,
  input wire       read_latch_i,
  input wire       read_pin_i,
  input wire       ext_bus_i,
  input wire       ext_data_move_i,
  // Outputs and pins
  input wire [7:0] bus_rdata_o,
  input wire       addr_latch_strobe_o,
  input wire       code_fetch_o,
  input wire [3:0] phase_o,
  input wire       ext_irq_a_o,
  input wire       timer_one_count_in_o,
  input wire       alt_rxd_o,
  input wire       ext_irq_b_o,
  input wire       timer_zero_count_in_o,
  input wire       third_timer_count_in_o,
  input wire       third_timer_trigger_o,
  input wire [7:0] p0_pin_o,
  input wire [7:0] p1_pin_i,
  input wire [7:0] p1_pin_o,
  input wire [7:0] p1_pin_oe_o,
  input wire [7:0] p3_pin_i,
  input wire [7:0] p3_pin_o,
  input wire [7:0] p3_pin_oe_o
);
  reg [3:0] age;
  always @(posedge clk_i) age <= sys_rst_i ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_wrap; phase_o == 4'hb |=> phase_o == 4'h0; endproperty
  a_wrap: assert property (p_wrap) else $error("phase wrap");
  property p_step; phase_o != 4'hb |=> phase_o == $past(phase_o) + 4'h1; endproperty
  a_step: assert property (p_step) else $error("phase step");
  property p_ale; phase_o == 4'h1 |-> addr_latch_strobe_o [*2] ##1 !addr_latch_strobe_o; endproperty
  a_ale: assert property (p_ale) else $error("strobe");
  property p_fetch; (!ext_data_move_i) [*3] ##0 (phase_o == 4'h1 || phase_o == 4'h6)
    |-> code_fetch_o; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch");
  property p_skip; ext_data_move_i [*3] |-> !code_fetch_o; endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_drv; p1_pin_oe_o == ~p1_pin_o && p3_pin_oe_o == ~p3_pin_o; endproperty
  a_drv: assert property (p_drv) else $error("drive");
  property p_open; (!ext_bus_i && age > 4'h4) [*3] |-> p0_pin_o == 8'h00; endproperty
  a_open: assert property (p_open) else $error("open drain");
  property p_rdpin; ($stable(p1_pin_i) && age > 4'h4) [*4] ##0
    (read_pin_i && !read_latch_i && port_sel_i == 2'h1) |=> bus_rdata_o == $past(p1_pin_i);
  endproperty
  a_rdpin: assert property (p_rdpin) else $error("read pin");
  property p_altin; ($stable(p3_pin_i) && age > 4'h4) [*4]
    |-> ext_irq_a_o == p3_pin_i[2] && timer_one_count_in_o == p3_pin_i[5] &&
        alt_rxd_o == p3_pin_i[0] && ext_irq_b_o == p3_pin_i[3] &&
        timer_zero_count_in_o == p3_pin_i[4]; endproperty
  a_altin: assert property (p_altin) else $error("alt input");
  property p_t2in; ($stable(p1_pin_i) && age > 4'h4) [*4]
    |-> third_timer_count_in_o == p1_pin_i[0] && third_timer_trigger_o == p1_pin_i[1];
  endproperty
  a_t2in: assert property (p_t2in) else $error("third timer input");
endmodule // qbpu_port_unit_chk
bind qbpu_port_unit qbpu_port_unit_chk qbpu_port_unit_chk_inst (.clk_i, .sys_rst_i,
  .port_sel_i, .read_latch_i, .read_pin_i, .ext_bus_i, .ext_data_move_i, .bus_rdata_o,
  .addr_latch_strobe_o, .code_fetch_o, .phase_o, .ext_irq_a_o, .timer_one_count_in_o,
  .alt_rxd_o, .ext_irq_b_o, .timer_zero_count_in_o, .third_timer_count_in_o,
  .third_timer_trigger_o,
  .p0_pin_o, .p1_pin_i, .p1_pin_o, .p1_pin_oe_o, .p3_pin_i, .p3_pin_o, .p3_pin_oe_o);

// ### bench/tb_quasi_bidir_port_unit.sv
/* Self-checking bench for the port unit.
   Assumes the pin model on the far side and the bound checker. */
`timescale 1ns/1ns
module tb_quasi_bidir_port_unit;
  logic clk_i = 0, sys_rst_i = 1, write_latch_i = 0, read_latch_i = 0, read_pin_i = 0;
  logic bit_op_i = 0, ext_bus_i = 0, addr16_i = 0, ext_data_phase_i = 0, ext_write_i = 0;
  logic ext_data_move_i = 0, alt_txd_i = 1, alt_wr_i = 1, alt_rd_i = 1, pend = 0;
  logic [1:0]  port_sel_i = 0;
  logic [2:0]  bit_sel_i = 0;
  logic [7:0]  bus_wdata_i = 0, ext_addr_lo_i = 0, ext_addr_hi_i = 0, ext_wdata_i = 0, v, r;
  logic [31:0] ext_v = 0, ext_en = 0;
  logic [7:0]  exp_q[$];
  wire  [7:0]  bus_rdata_o, ext_rdata_o, p0_pin_i, p1_pin_i, p2_pin_i, p3_pin_i;
  wire  [7:0]  p0_pin_o, p1_pin_o, p2_pin_o, p3_pin_o;
  wire  [7:0]  p0_pin_oe_o, p1_pin_oe_o, p2_pin_oe_o, p3_pin_oe_o;
  int          n_errors = 0, n_compared = 0;
  always #50 clk_i = ~clk_i;
  qbpu_port_unit qbpu_port_unit_inst (.clk_i, .sys_rst_i, .port_sel_i, .write_latch_i,
    .read_latch_i, .read_pin_i, .bit_op_i, .bit_sel_i, .bus_wdata_i, .bus_rdata_o, .ext_bus_i,
    .addr16_i, .ext_data_phase_i, .ext_write_i, .ext_data_move_i, .ext_addr_lo_i,
    .ext_addr_hi_i, .ext_wdata_i, .ext_rdata_o, .alt_txd_i, .alt_wr_i, .alt_rd_i,
    .alt_rxd_o(), .ext_irq_a_o(), .ext_irq_b_o(), .timer_zero_count_in_o(),
    .timer_one_count_in_o(), .third_timer_count_in_o(), .third_timer_trigger_o(),
    .addr_latch_strobe_o(), .code_fetch_o(), .phase_o(), .p0_pin_i, .p0_pin_o, .p0_pin_oe_o,
    .p1_pin_i, .p1_pin_o, .p1_pin_oe_o, .p2_pin_i, .p2_pin_o, .p2_pin_oe_o, .p3_pin_i,
    .p3_pin_o, .p3_pin_oe_o);
  qbpu_pin_model qbpu_pin_model_inst (.clk_i, .drv_i({p3_pin_o, p2_pin_o, p1_pin_o, p0_pin_o}),
    .oe_i({p3_pin_oe_o, p2_pin_oe_o, p1_pin_oe_o, p0_pin_oe_o}), .ext_v_i(ext_v),
    .ext_en_i(ext_en), .pin_o({p3_pin_i, p2_pin_i, p1_pin_i, p0_pin_i}));
  task cmp(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task conclude;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input logic [1:0] p, input logic [7:0] d, input logic bo = 0, input logic [2:0] bs = 0);
    @(posedge clk_i);
    port_sel_i <= p; bus_wdata_i <= d; bit_op_i <= bo; bit_sel_i <= bs; write_latch_i <= 1;
    @(posedge clk_i);
    write_latch_i <= 0;
    repeat (18) @(posedge clk_i);
  endtask
  task rd(input logic [1:0] p, input logic pn, input logic [7:0] e);
    @(posedge clk_i);
    port_sel_i <= p; read_latch_i <= ~pn; read_pin_i <= pn;
    exp_q.push_back(e);
    @(posedge clk_i);
    read_latch_i <= 0; read_pin_i <= 0;
    @(posedge clk_i);
  endtask
  // Read result monitor
  always @(posedge clk_i) begin
    if (pend && exp_q.size() > 0) cmp(exp_q.pop_front(), bus_rdata_o);
    pend <= read_latch_i | read_pin_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    conclude;
  end
  initial begin
    v = $urandom(32'h2e4a);
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 0;
    for (int i = 0; i < 4; i++) rd(i[1:0], 1'b0, 8'hff);
    $display("reset test done");
    r = $urandom; wr(2'h1, r); rd(2'h1, 1'b0, r); rd(2'h1, 1'b1, r);
    wr(2'h1, 8'hff); ext_en[15:8] <= r; repeat (5) @(posedge clk_i);
    rd(2'h1, 1'b1, ~r); rd(2'h1, 1'b0, 8'hff);
    ext_en <= 0; wr(2'h1, 8'h00, 1'b1, 3'h3); rd(2'h1, 1'b0, 8'hf7);
    wr(2'h1, 8'hff); rd(2'h1, 1'b1, 8'hff);
    for (int i = 0; i < 3; i++) begin
      {alt_txd_i, alt_wr_i, alt_rd_i} <= 3'($urandom); r = 8'($urandom); wr(2'h3, r);
      rd(2'h3, 1'b1, r & {alt_rd_i, alt_wr_i, 4'hf, alt_txd_i, 1'b1});
    end
    $display("port test done");
    ext_v[7:0] <= v; ext_en[7:0] <= 8'hff; repeat (5) @(posedge clk_i);
    rd(2'h0, 1'b1, v); wr(2'h0, 8'h0f); rd(2'h0, 1'b1, v & 8'h0f);
    r = $urandom; wr(2'h2, r); ext_en <= 0; ext_bus_i <= 1; ext_data_move_i <= 1;
    ext_addr_lo_i <= $urandom; ext_addr_hi_i <= $urandom; repeat (6) @(posedge clk_i);
    rd(2'h0, 1'b1, ext_addr_lo_i); rd(2'h2, 1'b1, r);
    addr16_i <= 1; repeat (6) @(posedge clk_i); rd(2'h2, 1'b1, ext_addr_hi_i);
    ext_data_phase_i <= 1; ext_write_i <= 1; ext_wdata_i <= $urandom;
    repeat (6) @(posedge clk_i); rd(2'h0, 1'b1, ext_wdata_i);
    ext_write_i <= 0; ext_v[7:0] <= ~v; ext_en[7:0] <= 8'hff; repeat (6) @(posedge clk_i);
    cmp(~v, ext_rdata_o);
    wr(2'h0, 8'h00); wr(2'h2, 8'h3c); rd(2'h0, 1'b0, 8'hff); rd(2'h2, 1'b0, r);
    ext_bus_i <= 0; ext_data_move_i <= 0; ext_en <= 0; repeat (6) @(posedge clk_i);
    $display("bus test done");
    conclude;
  end
endmodule // tb_quasi_bidir_port_unit
